// >>> drp_pkg.sv
// Shared constants, field layouts and types of the ramp and profile bank
`default_nettype none
package drp_pkg;
   // -----------------------------------------------------------------
   // Register offsets
   // -----------------------------------------------------------------
   localparam logic [4:0] ADDR_BOUND = 5'h0B;
   localparam logic [4:0] ADDR_INCR = 5'h0C;
   localparam logic [4:0] ADDR_INTERVAL = 5'h0D;
   localparam logic [4:0] ADDR_SLOT_FIRST = 5'h0E;
   localparam logic [4:0] ADDR_SLOT_LAST = 5'h15;
   localparam logic [4:0] ADDR_MEM_PORT = 5'h16;
   // -----------------------------------------------------------------
   // Control word bit positions
   // -----------------------------------------------------------------
   localparam int CF1_MEM_ENABLE = 31;
   localparam int CF1_AUTO_LSB = 17;
   localparam int CF1_AUTO_W = 4;
   localparam int CF2_SWEEP_ENABLE = 19;
   localparam int CF2_TONE_INHIBIT = 4;
   // -----------------------------------------------------------------
   // Field positions (lsb and width)
   // -----------------------------------------------------------------
   localparam int HI_LSB = 32;
   localparam int LO_LSB = 0;
   localparam int HALF_W = 32;
   localparam int RATE_NEG_LSB = 16;
   localparam int RATE_POS_LSB = 0;
   localparam int RATE_W = 16;
   localparam int TONE_AMP_LSB = 48;
   localparam int TONE_AMP_W = 14;
   localparam int TONE_PHASE_LSB = 32;
   localparam int TONE_PHASE_W = 16;
   localparam int TONE_FREQ_LSB = 0;
   localparam int TONE_FREQ_W = 32;
   localparam int MEM_RATE_LSB = 40;
   localparam int MEM_RATE_W = 16;
   localparam int MEM_END_LSB = 30;
   localparam int MEM_START_LSB = 14;
   localparam int MEM_AW = 10;
   localparam int MEM_NO_DWELL_BIT = 5;
   localparam int MEM_ZERO_CROSS_BIT = 3;
   localparam int MEM_MODE_LSB = 0;
   localparam int MEM_MODE_W = 3;
   // -----------------------------------------------------------------
   // Reset values, writable masks and memory modes
   // -----------------------------------------------------------------
   localparam logic [63:0] REG_RESET = 64'h0000_0000_0000_0000;
   localparam logic [31:0] WORD_RESET = 32'h0000_0000;
   localparam logic [2:0] SLOT_RESET = 3'h0;
   localparam logic [63:0] MASK_FULL = 64'hFFFF_FFFF_FFFF_FFFF;
   localparam logic [63:0] MASK_WORD = 64'h0000_0000_FFFF_FFFF;
   localparam logic [63:0] MASK_SLOT = 64'h3FFF_FFFF_FFFF_FFFF;
   localparam logic [63:0] MASK_NONE = 64'h0000_0000_0000_0000;
   localparam logic [2:0] MEM_MODE_DIRECT = 3'h0;
   localparam logic [2:0] MEM_MODE_RAMP_UP = 3'h1;

   // Memory load sequencer states
   typedef enum logic [2:0] {
      MEM_IDLE = 3'h1,
      MEM_ACTIVE = 3'h2,
      MEM_FULL = 3'h4
   } drp_mem_state_e;

   // Writable bits of each offset; zero means not in this bank
   function automatic logic [63:0] field_mask(input logic [4:0] addr);
      logic [63:0] m;
      m = MASK_NONE;
      if (addr == ADDR_BOUND || addr == ADDR_INCR) begin
         m = MASK_FULL;
      end else if (addr == ADDR_INTERVAL || addr == ADDR_MEM_PORT) begin
         m = MASK_WORD;
      end else if (addr >= ADDR_SLOT_FIRST && addr <= ADDR_SLOT_LAST) begin
         m = MASK_SLOT;
      end
      return m;
   endfunction
endpackage
`default_nettype wire

// >>> drp_pin_sync.sv
// Two-stage synchroniser for the profile select pins
`default_nettype none
module drp_pin_sync (
   input wire logic CLK,
   input wire logic SYS_RST,
   input wire logic [2:0] pin_in,
   output logic [2:0] pin_sync
);
   logic [2:0] stage1_ff;
   logic [2:0] stage2_ff;

   // First stage feeds only the second stage
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         stage1_ff <= drp_pkg::SLOT_RESET;
         stage2_ff <= drp_pkg::SLOT_RESET;
      end else begin
         stage1_ff <= pin_in;
         stage2_ff <= stage1_ff;
      end
   end

   assign pin_sync = stage2_ff;
endmodule // drp_pin_sync
`default_nettype wire

// >>> drp_slot_decode.sv
// Splits one profile word into its tone and memory control fields
`default_nettype none
module drp_slot_decode (
   input wire logic [63:0] word,
   output logic [13:0] amp,
   output logic [15:0] phase,
   output logic [31:0] freq,
   output logic [15:0] step_rate,
   output logic [9:0] end_addr,
   output logic [9:0] start_addr,
   output logic no_dwell,
   output logic zero_cross,
   output logic [2:0] mode
);
   // Tone layout fields
   assign amp = word[drp_pkg::TONE_AMP_LSB +: drp_pkg::TONE_AMP_W];
   assign phase = word[drp_pkg::TONE_PHASE_LSB +: drp_pkg::TONE_PHASE_W];
   assign freq = word[drp_pkg::TONE_FREQ_LSB +: drp_pkg::TONE_FREQ_W];

   // Memory control fields; open bits are simply not picked up
   assign step_rate = word[drp_pkg::MEM_RATE_LSB +: drp_pkg::MEM_RATE_W];
   assign end_addr = word[drp_pkg::MEM_END_LSB +: drp_pkg::MEM_AW];
   assign start_addr = word[drp_pkg::MEM_START_LSB +: drp_pkg::MEM_AW];
   assign no_dwell = word[drp_pkg::MEM_NO_DWELL_BIT];
   assign zero_cross = word[drp_pkg::MEM_ZERO_CROSS_BIT];
   assign mode = word[drp_pkg::MEM_MODE_LSB +: drp_pkg::MEM_MODE_W];
endmodule // drp_slot_decode
`default_nettype wire

// >>> drp_regs.sv
// Ramp, profile and waveform memory port register bank
`default_nettype none
module drp_regs (
   input wire logic CLK,
   input wire logic SYS_RST,
   input wire logic REG_WR_EN,
   input wire logic REG_RD_EN,
   input wire logic [4:0] REG_ADDR,
   input wire logic [63:0] REG_WDATA,
   output logic [63:0] REG_RDATA,
   output logic REG_ADDR_MISS,
   input wire logic [31:0] CTRL_WORD_ONE,
   input wire logic [31:0] CTRL_WORD_TWO,
   input wire logic [2:0] PROFILE_PINS,
   input wire logic [2:0] AUTO_PROFILE,
   output logic SWEEP_ENABLED,
   output logic [31:0] RAMP_UPPER,
   output logic [31:0] RAMP_LOWER,
   output logic [31:0] RAMP_DEC_STEP,
   output logic [31:0] RAMP_INC_STEP,
   output logic [15:0] RAMP_NEG_RATE,
   output logic [15:0] RAMP_POS_RATE,
   output logic [2:0] ACTIVE_PROFILE,
   output logic TONE_LAYOUT,
   output logic MEM_LAYOUT,
   output logic [13:0] TONE_AMPLITUDE,
   output logic [15:0] TONE_PHASE,
   output logic [31:0] TONE_FREQ,
   output logic [15:0] MEM_STEP_RATE,
   output logic [9:0] MEM_END_ADDR,
   output logic [9:0] MEM_START_ADDR,
   output logic [2:0] MEM_MODE,
   output logic MEM_NO_DWELL,
   output logic MEM_ZERO_CROSS,
   output logic MEM_WR_EN,
   output logic [9:0] MEM_WR_ADDR,
   output logic [31:0] MEM_WR_DATA,
   output logic MEM_XFER_DONE
);
   // -----------------------------------------------------------------
   // Declarations
   // -----------------------------------------------------------------
   logic [63:0] bound_ff;
   logic [63:0] incr_ff;
   logic [31:0] interval_ff;
   logic [63:0] slot_ff [8];
   logic [31:0] mem_word_ff;
   logic [63:0] wr_mask;
   logic [63:0] wr_val;
   logic [2:0] wr_slot;
   logic wr_is_slot;
   logic [2:0] pins_sync;
   logic sweep_c;
   logic mem_c;
   logic tone_c;
   logic auto_sel;
   logic [2:0] nxt_active;
   logic [2:0] active_ff;
   logic [63:0] act_word;
   logic [13:0] d_amp;
   logic [15:0] d_phase;
   logic [31:0] d_freq;
   logic [15:0] d_rate;
   logic [9:0] d_end;
   logic [9:0] d_start;
   logic d_no_dwell;
   logic d_zero;
   logic [2:0] d_mode;
   drp_pkg::drp_mem_state_e mem_state_ff;
   drp_pkg::drp_mem_state_e nxt_mem_state;
   logic [9:0] ptr_ff;
   logic [9:0] wr_ptr;
   logic mem_take;
   logic rearm_c;

   // -----------------------------------------------------------------
   // Pin synchroniser and active slot decoder
   // -----------------------------------------------------------------
   drp_pin_sync u_pin_sync (
      .CLK(CLK),
      .SYS_RST(SYS_RST),
      .pin_in(PROFILE_PINS),
      .pin_sync(pins_sync)
   );

   drp_slot_decode u_slot_decode (
      .word(act_word),
      .amp(d_amp),
      .phase(d_phase),
      .freq(d_freq),
      .step_rate(d_rate),
      .end_addr(d_end),
      .start_addr(d_start),
      .no_dwell(d_no_dwell),
      .zero_cross(d_zero),
      .mode(d_mode)
   );

   // -----------------------------------------------------------------
   // Write decode
   // -----------------------------------------------------------------
   // Mask strips open bits before anything is stored
   assign wr_mask = drp_pkg::field_mask(REG_ADDR);
   assign wr_val = REG_WDATA & wr_mask;
   assign wr_slot = 3'(REG_ADDR - drp_pkg::ADDR_SLOT_FIRST);
   assign wr_is_slot = REG_WR_EN && REG_ADDR >= drp_pkg::ADDR_SLOT_FIRST &&
                       REG_ADDR <= drp_pkg::ADDR_SLOT_LAST;

   // Ramp registers keep their value until rewritten
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         bound_ff <= drp_pkg::REG_RESET;
         incr_ff <= drp_pkg::REG_RESET;
         interval_ff <= drp_pkg::WORD_RESET;
      end else if (REG_WR_EN) begin
         if (REG_ADDR == drp_pkg::ADDR_BOUND) begin
            bound_ff <= wr_val;
         end
         if (REG_ADDR == drp_pkg::ADDR_INCR) begin
            incr_ff <= wr_val;
         end
         if (REG_ADDR == drp_pkg::ADDR_INTERVAL) begin
            interval_ff <= wr_val[31:0];
         end
      end
   end

   // Eight profile slots, one offset each
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         for (int i = 0; i < 8; i++) begin
            slot_ff[i] <= drp_pkg::REG_RESET;
         end
      end else if (wr_is_slot) begin
         slot_ff[wr_slot] <= wr_val;
      end
   end

   // Last word sent through the memory port, read back by software
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         mem_word_ff <= drp_pkg::WORD_RESET;
      end else if (REG_WR_EN && REG_ADDR == drp_pkg::ADDR_MEM_PORT) begin
         mem_word_ff <= wr_val[31:0];
      end
   end

   // -----------------------------------------------------------------
   // Read path
   // -----------------------------------------------------------------
   // Read data is valid the cycle after the read strobe
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         REG_RDATA <= drp_pkg::REG_RESET;
         REG_ADDR_MISS <= 1'b0;
      end else begin
         REG_ADDR_MISS <= (REG_WR_EN || REG_RD_EN) &&
                          drp_pkg::field_mask(REG_ADDR) == drp_pkg::MASK_NONE;
         if (REG_RD_EN) begin
            case (REG_ADDR)
               drp_pkg::ADDR_BOUND: REG_RDATA <= bound_ff;
               drp_pkg::ADDR_INCR: REG_RDATA <= incr_ff;
               drp_pkg::ADDR_INTERVAL: REG_RDATA <= {32'h0, interval_ff};
               drp_pkg::ADDR_MEM_PORT: REG_RDATA <= {32'h0, mem_word_ff};
               default: begin
                  if (wr_is_slot || REG_ADDR >= drp_pkg::ADDR_SLOT_FIRST &&
                      REG_ADDR <= drp_pkg::ADDR_SLOT_LAST) begin
                     REG_RDATA <= slot_ff[wr_slot];
                  end else begin
                     REG_RDATA <= drp_pkg::REG_RESET;
                  end
               end
            endcase
         end
      end
   end

   // -----------------------------------------------------------------
   // Mode decode and ramp outputs
   // -----------------------------------------------------------------
   assign sweep_c = CTRL_WORD_TWO[drp_pkg::CF2_SWEEP_ENABLE];
   assign mem_c = CTRL_WORD_ONE[drp_pkg::CF1_MEM_ENABLE];
   assign tone_c = !mem_c && !sweep_c &&
                   !CTRL_WORD_TWO[drp_pkg::CF2_TONE_INHIBIT];

   // Ramp values reach the sweep generator only while it is enabled
   always_ff @(posedge CLK) begin
      if (SYS_RST || !sweep_c) begin
         SWEEP_ENABLED <= 1'b0;
         RAMP_UPPER <= drp_pkg::WORD_RESET;
         RAMP_LOWER <= drp_pkg::WORD_RESET;
         RAMP_DEC_STEP <= drp_pkg::WORD_RESET;
         RAMP_INC_STEP <= drp_pkg::WORD_RESET;
         RAMP_NEG_RATE <= 16'h0000;
         RAMP_POS_RATE <= 16'h0000;
      end else begin
         SWEEP_ENABLED <= 1'b1;
         RAMP_UPPER <= bound_ff[drp_pkg::HI_LSB +: drp_pkg::HALF_W];
         RAMP_LOWER <= bound_ff[drp_pkg::LO_LSB +: drp_pkg::HALF_W];
         RAMP_DEC_STEP <= incr_ff[drp_pkg::HI_LSB +: drp_pkg::HALF_W];
         RAMP_INC_STEP <= incr_ff[drp_pkg::LO_LSB +: drp_pkg::HALF_W];
         RAMP_NEG_RATE <= interval_ff[drp_pkg::RATE_NEG_LSB +: drp_pkg::RATE_W];
         RAMP_POS_RATE <= interval_ff[drp_pkg::RATE_POS_LSB +: drp_pkg::RATE_W];
      end
   end

   // -----------------------------------------------------------------
   // Active profile selection
   // -----------------------------------------------------------------
   assign auto_sel = mem_c &&
      CTRL_WORD_ONE[drp_pkg::CF1_AUTO_LSB +: drp_pkg::CF1_AUTO_W] != 4'h0;
   assign nxt_active = auto_sel ? AUTO_PROFILE : pins_sync;
   assign act_word = slot_ff[active_ff];
   assign ACTIVE_PROFILE = active_ff;

   // Registered choice of the slot in force
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         active_ff <= drp_pkg::SLOT_RESET;
      end else begin
         active_ff <= nxt_active;
      end
   end

   // Layout flags and fields of the active slot
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         TONE_LAYOUT <= 1'b0;
         MEM_LAYOUT <= 1'b0;
         TONE_AMPLITUDE <= 14'h0000;
         TONE_PHASE <= 16'h0000;
         TONE_FREQ <= drp_pkg::WORD_RESET;
         MEM_STEP_RATE <= 16'h0000;
         MEM_END_ADDR <= 10'h000;
         MEM_START_ADDR <= 10'h000;
         MEM_MODE <= drp_pkg::MEM_MODE_DIRECT;
         MEM_NO_DWELL <= 1'b0;
         MEM_ZERO_CROSS <= 1'b0;
      end else begin
         TONE_LAYOUT <= tone_c;
         MEM_LAYOUT <= mem_c;
         TONE_AMPLITUDE <= tone_c ? d_amp : 14'h0000;
         TONE_PHASE <= tone_c ? d_phase : 16'h0000;
         TONE_FREQ <= tone_c ? d_freq : drp_pkg::WORD_RESET;
         MEM_STEP_RATE <= mem_c ? d_rate : 16'h0000;
         MEM_END_ADDR <= mem_c ? d_end : 10'h000;
         MEM_START_ADDR <= mem_c ? d_start : 10'h000;
         MEM_MODE <= mem_c ? d_mode : drp_pkg::MEM_MODE_DIRECT;
         MEM_NO_DWELL <= mem_c && d_no_dwell &&
                         d_mode == drp_pkg::MEM_MODE_RAMP_UP;
         MEM_ZERO_CROSS <= mem_c && d_zero &&
                           d_mode == drp_pkg::MEM_MODE_DIRECT;
      end
   end

   // -----------------------------------------------------------------
   // Waveform memory load sequencer
   // -----------------------------------------------------------------
   // A slot write or a change of active slot restarts the load
   assign rearm_c = wr_is_slot || nxt_active != active_ff;
   assign mem_take = REG_WR_EN && REG_ADDR == drp_pkg::ADDR_MEM_PORT &&
                     mem_state_ff != drp_pkg::MEM_FULL;
   assign wr_ptr = (mem_state_ff == drp_pkg::MEM_IDLE) ? d_start : ptr_ff;
   assign MEM_XFER_DONE = mem_state_ff == drp_pkg::MEM_FULL;

   // Next state: count runs from start to end, wrapping the address
   always_comb begin
      nxt_mem_state = mem_state_ff;
      case (mem_state_ff)
         drp_pkg::MEM_IDLE: begin
            if (mem_take) begin
               nxt_mem_state = (d_start == d_end) ? drp_pkg::MEM_FULL :
                               drp_pkg::MEM_ACTIVE;
            end
         end
         drp_pkg::MEM_ACTIVE: begin
            if (mem_take && ptr_ff == d_end) begin
               nxt_mem_state = drp_pkg::MEM_FULL;
            end
         end
         drp_pkg::MEM_FULL: nxt_mem_state = drp_pkg::MEM_FULL;
         default: nxt_mem_state = drp_pkg::MEM_IDLE;
      endcase
      if (rearm_c) begin
         nxt_mem_state = drp_pkg::MEM_IDLE;
      end
   end

   // Sequencer state and address pointer
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         mem_state_ff <= drp_pkg::MEM_IDLE;
         ptr_ff <= 10'h000;
      end else begin
         mem_state_ff <= nxt_mem_state;
         if (mem_take) begin
            ptr_ff <= wr_ptr + 10'h001;
         end
      end
   end

   // One write pulse per accepted word toward the waveform memory
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         MEM_WR_EN <= 1'b0;
         MEM_WR_ADDR <= 10'h000;
         MEM_WR_DATA <= drp_pkg::WORD_RESET;
      end else begin
         MEM_WR_EN <= mem_take;
         if (mem_take) begin
            MEM_WR_ADDR <= wr_ptr;
            MEM_WR_DATA <= REG_WDATA[31:0];
         end
      end
   end

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   chk_ramp_gate: assert property (
      @(posedge CLK) disable iff (SYS_RST)
      !sweep_c |=> !SWEEP_ENABLED && RAMP_UPPER == 32'h0 &&
                   RAMP_INC_STEP == 32'h0 && RAMP_POS_RATE == 16'h0)
      else $error("ramp outputs active while sweep disabled");

   chk_bound_split: assert property (
      @(posedge CLK) disable iff (SYS_RST)
      (REG_WR_EN && REG_ADDR == drp_pkg::ADDR_BOUND && sweep_c) ##1 sweep_c
      |=> RAMP_UPPER == $past(REG_WDATA[63:32], 2) &&
          RAMP_LOWER == $past(REG_WDATA[31:0], 2))
      else $error("bound halves misplaced");

   chk_step_split: assert property (
      @(posedge CLK) disable iff (SYS_RST)
      sweep_c |=> RAMP_DEC_STEP == $past(incr_ff[63:32]) &&
                  RAMP_INC_STEP == $past(incr_ff[31:0]))
      else $error("step halves misplaced");

   chk_rate_split: assert property (
      @(posedge CLK) disable iff (SYS_RST)
      sweep_c |=> {RAMP_NEG_RATE, RAMP_POS_RATE} == $past(interval_ff))
      else $error("interval halves misplaced");

   chk_slot_store: assert property (
      @(posedge CLK) disable iff (SYS_RST)
      (REG_WR_EN && REG_ADDR == drp_pkg::ADDR_SLOT_LAST)
      |=> slot_ff[7] == ($past(REG_WDATA) & drp_pkg::MASK_SLOT))
      else $error("last slot not stored");

   chk_layout_mem: assert property (
      @(posedge CLK) disable iff (SYS_RST)
      mem_c |=> MEM_LAYOUT && !TONE_LAYOUT)
      else $error("memory layout not selected");

   chk_layout_tone: assert property (
      @(posedge CLK) disable iff (SYS_RST)
      TONE_LAYOUT |-> !$past(mem_c) && !$past(sweep_c) &&
                      !$past(CTRL_WORD_TWO[drp_pkg::CF2_TONE_INHIBIT]))
      else $error("tone layout with a blocking bit set");

   chk_pin_select: assert property (
      @(posedge CLK) disable iff (SYS_RST)
      !$past(auto_sel) && !$past(SYS_RST) && !$past(SYS_RST, 2) &&
      !$past(SYS_RST, 3)
      |-> ACTIVE_PROFILE == $past(PROFILE_PINS, 3))
      else $error("active profile does not follow pins");

   chk_auto_select: assert property (
      @(posedge CLK) disable iff (SYS_RST)
      auto_sel |=> ACTIVE_PROFILE == $past(AUTO_PROFILE))
      else $error("automatic profile not applied");

   chk_tone_fields: assert property (
      @(posedge CLK) disable iff (SYS_RST)
      tone_c |=> TONE_FREQ == $past(act_word[31:0]) &&
                 TONE_AMPLITUDE == $past(act_word[61:48]))
      else $error("tone fields wrong");

   chk_mem_fields: assert property (
      @(posedge CLK) disable iff (SYS_RST)
      mem_c |=> MEM_END_ADDR == $past(act_word[39:30]) &&
                MEM_START_ADDR == $past(act_word[23:14]))
      else $error("memory address fields wrong");

   chk_no_dwell: assert property (
      @(posedge CLK) disable iff (SYS_RST)
      MEM_NO_DWELL |-> MEM_MODE == drp_pkg::MEM_MODE_RAMP_UP && MEM_LAYOUT)
      else $error("no-dwell outside ramp-up mode");

   chk_zero_cross: assert property (
      @(posedge CLK) disable iff (SYS_RST)
      MEM_ZERO_CROSS |-> MEM_MODE == drp_pkg::MEM_MODE_DIRECT && MEM_LAYOUT)
      else $error("zero-crossing outside direct switch");

   chk_mem_stop: assert property (
      @(posedge CLK) disable iff (SYS_RST)
      MEM_XFER_DONE && !rearm_c |=> !MEM_WR_EN)
      else $error("memory write past end address");

   chk_open_bits: assert property (
      @(posedge CLK) disable iff (SYS_RST)
      (REG_RD_EN && REG_ADDR == drp_pkg::ADDR_SLOT_FIRST)
      |=> REG_RDATA[63:62] == 2'h0)
      else $error("open profile bits read back set");

   chk_reg_hold: assert property (
      @(posedge CLK) disable iff (SYS_RST)
      !(REG_WR_EN && REG_ADDR == drp_pkg::ADDR_BOUND) |=> $stable(bound_ff))
      else $error("bound register changed without a write");
endmodule // drp_regs
`default_nettype wire

// >>> drp_host.sv
// Host side model issuing register bank accesses
`default_nettype none
module drp_host (
   input wire logic CLK,
   output logic wr,
   output logic rd,
   output logic [4:0] a,
   output logic [63:0] d
);
   timeunit 1ns;
   timeprecision 1ps;
   initial {wr, rd, a, d} = '0;
   // One access per call, data inverted once released
   task automatic acc(input logic w, r, input logic [4:0] ad,
                      input logic [63:0] v);
      @(posedge CLK);
      {wr, rd, a, d} <= {w, r, ad, v};
      @(posedge CLK);
      {wr, rd, d} <= {2'b00, ~v};
   endtask
endmodule // drp_host
`default_nettype wire

// >>> tb.sv
// Self-checking bench for the ramp and profile register bank
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, rst = 1, wr, rd, rd_d = 0, miss, swp, tl, ml, nd, zc;
   logic mwe, done;
   logic [4:0] a;
   logic [63:0] d, rdata, w;
   logic [63:0] v [0:7];
   logic [63:0] s [0:7];
   logic [31:0] ctl1 = 0, ctl2 = 0, up, lo, dec, inc, tf, mwd, dw;
   logic [15:0] nr, pr, tp, msr;
   logic [2:0] pins = 0, auto = 0, ap, mm;
   logic [13:0] ta;
   logic [9:0] me, ms, mwa;
   logic [64:0] rq [$];
   logic [64:0] mq [$];
   int seed, bad_count = 0, n_checks = 0, cyc = 0, i;
   drp_host i_drp_host(.CLK(clk), .wr(wr), .rd(rd), .a(a), .d(d));
   drp_regs i_drp_regs(.CLK(clk), .SYS_RST(rst), .REG_WR_EN(wr),
      .REG_RD_EN(rd), .REG_ADDR(a), .REG_WDATA(d), .REG_RDATA(rdata),
      .REG_ADDR_MISS(miss), .CTRL_WORD_ONE(ctl1), .CTRL_WORD_TWO(ctl2),
      .PROFILE_PINS(pins), .AUTO_PROFILE(auto), .SWEEP_ENABLED(swp),
      .RAMP_UPPER(up), .RAMP_LOWER(lo), .RAMP_DEC_STEP(dec),
      .RAMP_INC_STEP(inc), .RAMP_NEG_RATE(nr), .RAMP_POS_RATE(pr),
      .ACTIVE_PROFILE(ap), .TONE_LAYOUT(tl), .MEM_LAYOUT(ml),
      .TONE_AMPLITUDE(ta), .TONE_PHASE(tp), .TONE_FREQ(tf),
      .MEM_STEP_RATE(msr), .MEM_END_ADDR(me), .MEM_START_ADDR(ms),
      .MEM_MODE(mm), .MEM_NO_DWELL(nd), .MEM_ZERO_CROSS(zc),
      .MEM_WR_EN(mwe), .MEM_WR_ADDR(mwa), .MEM_WR_DATA(mwd),
      .MEM_XFER_DONE(done));
   // Clock at 25 MHz
   always #20 clk = ~clk;
   // Comparison with counting
   task automatic chk(input string nm, input logic [64:0] e, g);
      n_checks++;
      if (g !== e) begin
         bad_count++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask
   // Verdict and end of run
   task automatic final_report();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // Control inputs change, then outputs settle
   task automatic cfg(input logic [31:0] c1, c2, input logic [2:0] p, q);
      @(posedge clk);
      {ctl1, ctl2, pins, auto} <= {c1, c2, p, q};
      repeat (6) @(posedge clk);
      @(negedge clk);
   endtask
   // Read with its expected answer noted first
   task automatic rdx(input logic [4:0] ad, input logic [64:0] e);
      rq.push_back(e);
      i_drp_host.acc(0, 1, ad, 0);
   endtask
   // Match read answers and memory words with the oldest note
   always @(negedge clk) begin
      if (rd_d) chk("read", rq.pop_front(), {miss, rdata});
      if (mwe === 1'b1) chk("mem", mq.pop_front(), {mwa, mwd});
   end
   // Read tracking and hang limit
   always @(posedge clk) begin
      rd_d <= rd;
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         bad_count++;
         final_report();
      end
   end
   initial begin
      seed = 32'h5480ff48;
      repeat (12) @(posedge clk);
      rst <= 0;
      rdx(drp_pkg::ADDR_BOUND, 0);
      cfg(0, 32'h0008_0000, 0, 0);
      for (i = 0; i < 3; i++) begin
         v[i] = {$random(seed), $random(seed)};
         i_drp_host.acc(1, 0, drp_pkg::ADDR_BOUND + 5'(i), v[i]);
      end
      rdx(drp_pkg::ADDR_INCR, {1'b0, v[1]});
      rdx(drp_pkg::ADDR_INTERVAL, {1'b0, v[2] & drp_pkg::MASK_WORD});
      rdx(5'h1F, {1'b1, 64'h0});
      cfg(0, 32'h0008_0000, 0, 0);
      chk("up", v[0][63:32], up);
      chk("lo", v[0][31:0], lo);
      chk("dec", v[1][63:32], dec);
      chk("inc", v[1][31:0], inc);
      chk("rates", {v[2][31:16], v[2][15:0]}, {nr, pr});
      chk("swp", 1, swp);
      cfg(0, 0, 0, 0);
      chk("off", 0, {swp, up, lo});
      chk("off_step", 0, {dec, inc});
      chk("off_rate", 0, {nr, pr});
      $display("ramp test done");
      for (i = 0; i < 8; i++) begin
         s[i] = {$random(seed), $random(seed)};
         // Slot 2 carries ramp-up mode with no-dwell and zero-cross set
         if (i == 2) s[i][5:0] = 6'h29;
         i_drp_host.acc(1, 0, drp_pkg::ADDR_SLOT_FIRST + 5'(i), s[i]);
      end
      rdx(5'h13, {1'b0, s[5] & drp_pkg::MASK_SLOT});
      cfg(0, 0, 3'h5, 0);
      chk("tone", {1'b1, s[5][61:0]}, {tl, ta, tp, tf});
      cfg(0, 32'h0000_0010, 3'h5, 0);
      chk("none", 0, {tl, ml, tf});
      cfg(32'h8000_0000, 0, 3'h5, 0);
      chk("mem", {1'b1, s[5][55:30], s[5][23:14]}, {ml, msr, me, ms});
      cfg(32'h8002_0000, 0, 3'h5, 3'h2);
      chk("auto", 3'h2, ap);
      chk("nd", s[2][2:0] == 3'h1 && s[2][5], nd);
      chk("zc", s[2][2:0] == 3'h0 && s[2][3], zc);
      chk("mode", 3'h1, mm);
      $display("profile test done");
      w = 0;
      w[39:30] = 10'd1;
      w[23:14] = 10'd1022;
      w[3] = 1'b1;
      i_drp_host.acc(1, 0, 5'h10, w);
      for (i = 0; i < 5; i++) begin
         dw = $random(seed);
         if (i < 4) mq.push_back({23'h0, 10'(1022 + i), dw});
         i_drp_host.acc(1, 0, drp_pkg::ADDR_MEM_PORT, {32'h0, dw});
      end
      cfg(32'h8002_0000, 0, 3'h5, 3'h2);
      chk("done", 1, done);
      chk("zc_direct", 1, zc);
      chk("nd_direct", 0, nd);
      chk("left", 0, mq.size());
      $display("memory test done");
      final_report();
   end
endmodule // tb
`default_nettype wire
